// *** logic/rof_pkg.sv ***
// Purpose: types for the receive output and address filter
// Assumes: nothing
// Notes: character record from the decoder side
package rof_pkg;
  typedef struct packed {
    logic [11:0] raw; // undecoded bits, bit 0 first in
    logic [7:0] data; // decoded data
    logic special; // special character flag
    logic reserved; // reserved code flag
    logic cell_start; // start of cell flag
    logic is_addr; // serial address character
    logic cmd_set; // interrupt set command
    logic cmd_clr; // interrupt clear command
    logic valid; // character present this cycle
  } rof_char_t;
  typedef enum logic [2:0] {
    ROF_IDLE = 3'b001,
    ROF_SEL = 3'b010,
    ROF_READ = 3'b100
  } rof_state_t;
endpackage : rof_pkg

// *** logic/rof_regs.svh ***
// Purpose: constants for the receive output and address filter
// Assumes: included by bare name
// Notes: bit positions on the receive output bus
`ifndef ROF_REGS_SVH
`define ROF_REGS_SVH
`define ROF_BUS_W 12
`define ROF_ADDR_W 10
`define ROF_ADDR_RST 10'h3ff
`define ROF_BIT_INT 8
`define ROF_BIT_9 9
`define ROF_BIT_RVS 10
`define ROF_BIT_SOC 11
`define ROF_POL_KEEP 2'h0
`define ROF_POL_DROPADDR 2'h3
`define ROF_BYTE_W 8
`define ROF_RAW10_W 10
`define ROF_PAIR_ON 2'h0
`endif

// *** logic/rof_top.sv ***
// Purpose: receive output register, interrupt and serial address filter
// Assumes: all inputs synchronous to clk_in (the receive clock)
// Notes: pins are split into value and enable, no tri-state inside
// Contract
// RULE1: register host read controls every clock edge
// RULE2: output register clocked, flags float when deselected
// RULE3: select low then read enable starts read
// RULE4: output mapping follows bypass and width inputs
// RULE5: set and clear commands drive interrupt
// RULE6: interrupt mirrors far source interrupt transitions
// RULE7: decoded byte mode bit layout
// RULE8: undecoded bits keep arrival order
// RULE9: full bypass passes every character through
// RULE10: outside logic frames when unaligned
// RULE11: address register width follows data width
// RULE12: multicast matches any common domain bit
// RULE13: unicast matches whole address character
// RULE14: after match write address and data
// RULE15: mismatch blocks buffer writes
// RULE16: reset value all ones accepts everything
// RULE17: reset pair restores all ones address
// RULE18: bypassed buffer bit eight is odd parity
// RULE19: policy three also drops addresses
// RULE20: register access via bus while reset low
// RULE21: filter only with buffer on, policy nonzero
// RULE22: undecoded ten bit leaves top bits low
// RULE23: separate multicast and unicast values kept
`timescale 1ns/1ns
`include "rof_regs.svh"
module rof_top #(
  parameter int BUS_W = `ROF_BUS_W,
  parameter int ADDR_W = `ROF_ADDR_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic device_select_n_in,
  input wire logic read_enable_n_in,
  input wire logic codec_bypass_n_in,
  input wire logic width_select_in,
  input wire logic buffer_bypass_n_in,
  input wire logic receiver_reset_n_in,
  input wire logic [1:0] reset_pair_n_in,
  input wire logic [1:0] discard_policy_in,
  input wire logic [BUS_W-1:0] bus_in,
  input wire logic [2:0] buf_flags_in,
  input wire rof_pkg::rof_char_t char_in,
  output logic [BUS_W-1:0] receive_output_bus_out,
  output logic bus_oe_out,
  output logic [2:0] buf_flags_out,
  output logic buf_flags_oe_out,
  output logic far_interrupt_out,
  output logic buffer_write_out,
  output logic read_strobe_out
);
  logic sel_n_ff, nxt_sel_n;
  logic ren_n_ff, nxt_ren_n;
  rof_pkg::rof_state_t state_ff, nxt_state;
  logic [BUS_W-1:0] bus_ff, nxt_bus;
  logic oe_ff, nxt_oe;
  logic [2:0] flags_ff, nxt_flags;
  logic flags_oe_ff, nxt_flags_oe;
  logic int_ff, nxt_int;
  logic wr_ff, nxt_wr;
  logic pass_ff, nxt_pass;
  logic rd_ff, nxt_rd;
  logic [ADDR_W-1:0] mcast_ff, nxt_mcast;
  logic [ADDR_W-1:0] ucast_ff, nxt_ucast;
  logic mode_uni_ff, nxt_mode_uni;
  logic [ADDR_W-1:0] amask;
  logic [BUS_W-1:0] mapped;
  logic match, filter_on, promisc, reg_acc, parity;

  // address width mask, upper two bits unused in byte mode
  genvar gi;
  generate
    for (gi = 0; gi < ADDR_W; gi++)
    begin : g_mask
      assign amask[gi] = (gi < `ROF_BYTE_W) | ~width_select_in; // [RULE11]
    end
  endgenerate

  // match logic on the masked address character
  always_comb
  begin
    promisc = ((mcast_ff & amask) == amask) && !mode_uni_ff; // [RULE16]
    if (mode_uni_ff)
      match = ((char_in.raw[ADDR_W-1:0] & amask) == (ucast_ff & amask)); // [RULE13]
    else
      match = |(char_in.raw[ADDR_W-1:0] & mcast_ff & amask); // [RULE12]
    match = match | promisc;
    filter_on = buffer_bypass_n_in && (discard_policy_in != `ROF_POL_KEEP); // [RULE21]
    parity = ~^{char_in.data, char_in.special, char_in.reserved}; // [RULE18]
    reg_acc = !sel_n_ff && !receiver_reset_n_in; // [RULE20]
  end

  // bus mapping per decoder, width and buffer setting
  always_comb
  begin
    mapped = '0;
    if (codec_bypass_n_in && width_select_in)
    begin
      mapped[`ROF_BYTE_W-1:0] = char_in.data; // [RULE7]
      mapped[`ROF_BIT_INT] = buffer_bypass_n_in ? int_ff : parity; // [RULE7] [RULE18]
      mapped[`ROF_BIT_9] = 1'b0;
      mapped[`ROF_BIT_RVS] = char_in.reserved;
      mapped[`ROF_BIT_SOC] = char_in.cell_start;
    end
    else if (codec_bypass_n_in)
    begin
      mapped[`ROF_RAW10_W-1:0] = char_in.raw[`ROF_RAW10_W-1:0]; // unpacked ten bit data
      mapped[`ROF_BIT_RVS] = char_in.reserved;
      mapped[`ROF_BIT_SOC] = char_in.cell_start;
    end
    else if (width_select_in)
      mapped[`ROF_RAW10_W-1:0] = char_in.raw[`ROF_RAW10_W-1:0]; // [RULE8] [RULE22]
    else
      mapped = char_in.raw; // [RULE8] [RULE4]
  end

  // input register and read sequencing next values
  always_comb
  begin
    nxt_sel_n = device_select_n_in; // [RULE1]
    nxt_ren_n = read_enable_n_in; // [RULE1]
    nxt_state = state_ff;
    nxt_rd = 1'b0;
    nxt_oe = oe_ff;
    case (state_ff)
      rof_pkg::ROF_IDLE:
        if (!sel_n_ff)
          nxt_state = rof_pkg::ROF_SEL;
      rof_pkg::ROF_SEL:
        if (sel_n_ff)
          nxt_state = rof_pkg::ROF_IDLE;
        else if (!ren_n_ff)
        begin
          nxt_state = rof_pkg::ROF_READ; // [RULE3]
          nxt_oe = 1'b1;
          nxt_rd = 1'b1;
        end
      rof_pkg::ROF_READ:
        if (sel_n_ff || ren_n_ff)
        begin
          nxt_state = sel_n_ff ? rof_pkg::ROF_IDLE : rof_pkg::ROF_SEL;
          nxt_oe = 1'b0;
        end
        else
          nxt_rd = 1'b1;
      default:
        nxt_state = rof_pkg::ROF_IDLE;
    endcase
  end

  // input register and read sequencer flops, synchronous reset
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      sel_n_ff <= 1'b1;
      ren_n_ff <= 1'b1;
      state_ff <= rof_pkg::ROF_IDLE;
      oe_ff <= 1'b0;
      rd_ff <= 1'b0;
    end
    else
    begin
      sel_n_ff <= nxt_sel_n;
      ren_n_ff <= nxt_ren_n;
      state_ff <= nxt_state;
      oe_ff <= nxt_oe;
      rd_ff <= nxt_rd;
    end
  end

  // output register next values; the bus holds when neither a character nor a register read arrives
  always_comb
  begin
    // bus written every edge; fully bypassed path passes raw characters
    nxt_bus = (char_in.valid ? mapped : bus_ff); // [RULE2] [RULE9] [RULE10]
    if (reg_acc && char_in.reserved)
      nxt_bus = {{(BUS_W-ADDR_W){1'b0}},
        (char_in.special ? ucast_ff : mcast_ff) & amask}; // [RULE20]
    nxt_flags = buf_flags_in;
    nxt_flags_oe = !sel_n_ff; // [RULE2]
  end

  // output register flops; bus keeps its last value until a character or a register read arrives
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      bus_ff <= '0;
      flags_ff <= '0;
      flags_oe_ff <= 1'b0;
    end
    else
    begin
      bus_ff <= nxt_bus;
      flags_ff <= nxt_flags;
      flags_oe_ff <= nxt_flags_oe;
    end
  end

  // interrupt follows embedded commands only with decoder and buffer on
  always_comb
  begin
    nxt_int = int_ff;
    if (char_in.valid && codec_bypass_n_in && buffer_bypass_n_in)
    begin
      if (char_in.cmd_set)
        nxt_int = 1'b1; // set wins over clear [RULE5] [RULE6]
      else if (char_in.cmd_clr)
        nxt_int = 1'b0; // [RULE5] [RULE6]
    end
  end

  // interrupt flop
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      int_ff <= 1'b0;
    else
      int_ff <= nxt_int;
  end

  // filter gate and buffer write strobe
  always_comb
  begin
    nxt_pass = pass_ff;
    nxt_wr = 1'b0;
    if (char_in.valid && buffer_bypass_n_in)
    begin
      if (char_in.is_addr && filter_on)
      begin
        nxt_pass = match; // [RULE14] [RULE15]
        nxt_wr = match && (discard_policy_in != `ROF_POL_DROPADDR); // [RULE14] [RULE19]
      end
      else if ((char_in.cmd_set || char_in.cmd_clr) && codec_bypass_n_in
        && discard_policy_in != `ROF_POL_KEEP)
        nxt_wr = 1'b0; // commands removed from stream [RULE5]
      else
        nxt_wr = !filter_on || pass_ff || promisc; // [RULE15] [RULE16]
    end
    // reset pair reopens the gate together with the register
    if (reset_pair_n_in == `ROF_PAIR_ON)
      nxt_pass = 1'b1; // [RULE17]
  end

  // gate flops; reset leaves the gate open to match the promiscuous value
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ff <= 1'b0;
      pass_ff <= 1'b1;
    end
    else
    begin
      wr_ff <= nxt_wr;
      pass_ff <= nxt_pass;
    end
  end

  // address register: host write access and reset pair
  always_comb
  begin
    nxt_mcast = mcast_ff;
    nxt_ucast = ucast_ff;
    nxt_mode_uni = mode_uni_ff;
    // write access: reserved low selects write, special picks the mode
    if (reg_acc && !ren_n_ff && !char_in.reserved)
    begin
      nxt_mode_uni = char_in.special; // [RULE23]
      if (char_in.special)
        nxt_ucast = bus_in[ADDR_W-1:0] & amask;
      else
        nxt_mcast = bus_in[ADDR_W-1:0] & amask;
    end
    // reset pair wins over a same-cycle host write for mode and multicast value; a unicast write still loads
    if (reset_pair_n_in == `ROF_PAIR_ON)
    begin
      nxt_mcast = `ROF_ADDR_RST; // [RULE17]
      nxt_mode_uni = 1'b0;
    end
  end

  // address register flops; unicast value kept apart from multicast
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      mcast_ff <= `ROF_ADDR_RST; // [RULE16]
      ucast_ff <= '0;
      mode_uni_ff <= 1'b0;
    end
    else
    begin
      mcast_ff <= nxt_mcast;
      ucast_ff <= nxt_ucast;
      mode_uni_ff <= nxt_mode_uni;
    end
  end

  assign receive_output_bus_out = bus_ff;
  assign bus_oe_out = oe_ff;
  assign buf_flags_out = flags_ff;
  assign buf_flags_oe_out = flags_oe_ff;
  assign far_interrupt_out = int_ff;
  assign buffer_write_out = wr_ff;
  assign read_strobe_out = rd_ff;
endmodule : rof_top

// *** tb/rof_host.sv ***
// Purpose: host read controller model
// Assumes: go_in held for a whole burst
// Notes: select leads read enable by one cycle
`timescale 1ns/1ns
module rof_host (
  input wire logic clk_in,
  input wire logic go_in,
  output logic device_select_n_out = 1'b1,
  output logic read_enable_n_out = 1'b1
);
  // read enable never leads select, so no read is refused
  always @(posedge clk_in)
  begin
    device_select_n_out <= !go_in;
    read_enable_n_out <= !go_in || device_select_n_out;
  end
endmodule : rof_host

// *** tb/rof_properties.sv ***
// Purpose: port checks for the receive output block
// Assumes: one clock, sync reset high
// Notes: up_ff keeps $past clear of reset
`timescale 1ns/1ns
module rof_chk #(parameter int BUS_W = 12) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic device_select_n_in,
  input wire logic read_enable_n_in,
  input wire logic codec_bypass_n_in,
  input wire logic width_select_in,
  input wire logic buffer_bypass_n_in,
  input wire logic receiver_reset_n_in,
  input wire rof_pkg::rof_char_t char_in,
  input wire logic [BUS_W-1:0] receive_output_bus_out,
  input wire logic bus_oe_out,
  input wire logic buf_flags_oe_out,
  input wire logic far_interrupt_out,
  input wire logic read_strobe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic [1:0] up_ff;
  logic [1:0] nxt_up;
  rof_pkg::rof_char_t ch_ff;
  rof_pkg::rof_char_t nxt_ch;
  logic cmd_ok;
  // last character kept, since the bus shows it one edge on
  always_comb
  begin
    nxt_up = sys_rst_in ? 2'h0 : up_ff + {1'b0, up_ff != 2'h3};
    nxt_ch = char_in;
  end
  always_ff @(posedge clk_in)
  begin
    up_ff <= nxt_up;
    ch_ff <= nxt_ch;
  end
  assign cmd_ok = codec_bypass_n_in && buffer_bypass_n_in && char_in.valid;
  flags_float_a: assert property (up_ff == 2'h3 |->
    buf_flags_oe_out == !$past(device_select_n_in, 2)) else $error("flag enable wrong");
  read_start_a: assert property (!device_select_n_in ##1 !read_enable_n_in |->
    ##2 bus_oe_out && read_strobe_out) else $error("read did not start");
  read_stop_a: assert property (up_ff == 2'h3 && $past(read_enable_n_in, 2) |->
    !bus_oe_out && !read_strobe_out) else $error("read without enable");
  int_set_a: assert property (cmd_ok && char_in.cmd_set |=> far_interrupt_out)
    else $error("interrupt not set");
  int_clear_a: assert property (cmd_ok && char_in.cmd_clr && !char_in.cmd_set |=>
    !far_interrupt_out) else $error("interrupt not cleared");
  int_hold_a: assert property (!(cmd_ok && (char_in.cmd_set || char_in.cmd_clr)) |=>
    $stable(far_interrupt_out)) else $error("interrupt moved");
  byte_map_a: assert property (codec_bypass_n_in && !buffer_bypass_n_in && width_select_in
    && receiver_reset_n_in && char_in.valid |=> receive_output_bus_out == {ch_ff.cell_start,
    ch_ff.reserved, 1'b0, ~^{ch_ff.data, ch_ff.special, ch_ff.reserved}, ch_ff.data})
    else $error("byte layout wrong");
  raw_map_a: assert property (!codec_bypass_n_in && !width_select_in && char_in.valid
    |=> receive_output_bus_out == ch_ff.raw) else $error("raw layout wrong");
endmodule : rof_chk

// *** tb/rof_top_tb.sv ***
// Purpose: self-checking bench for the receive output block
// Assumes: host model drives select and read enable
// Notes: filter expectations follow the last register write
`timescale 1ns/1ns
module rof_top_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic codec_bypass_n_in = 1'b1;
  logic width_select_in = 1'b1;
  logic buffer_bypass_n_in = 1'b1;
  logic receiver_reset_n_in = 1'b1;
  logic [1:0] reset_pair_n_in = 2'h3;
  logic [1:0] discard_policy_in = 2'h2;
  logic [11:0] bus_in = 12'h000;
  logic [2:0] buf_flags_in = 3'h0;
  logic go = 1'b0;
  rof_pkg::rof_char_t char_in = '0;
  logic device_select_n_in, read_enable_n_in, bus_oe_out, buf_flags_oe_out;
  logic far_interrupt_out, buffer_write_out, read_strobe_out;
  logic [11:0] receive_output_bus_out;
  logic [2:0] buf_flags_out;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 32'h52da66f9;
  rof_top u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .device_select_n_in(device_select_n_in), .read_enable_n_in(read_enable_n_in),
    .codec_bypass_n_in(codec_bypass_n_in), .width_select_in(width_select_in),
    .buffer_bypass_n_in(buffer_bypass_n_in), .receiver_reset_n_in(receiver_reset_n_in),
    .reset_pair_n_in(reset_pair_n_in), .discard_policy_in(discard_policy_in),
    .bus_in(bus_in), .buf_flags_in(buf_flags_in), .char_in(char_in),
    .receive_output_bus_out(receive_output_bus_out), .bus_oe_out(bus_oe_out),
    .buf_flags_out(buf_flags_out), .buf_flags_oe_out(buf_flags_oe_out),
    .far_interrupt_out(far_interrupt_out), .buffer_write_out(buffer_write_out),
    .read_strobe_out(read_strobe_out));
  rof_host u_host (.clk_in, .go_in(go), .device_select_n_out(device_select_n_in),
    .read_enable_n_out(read_enable_n_in));
  always #4 clk_in = ~clk_in;
  // hang guard, well past the longest sequence
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  function automatic rof_pkg::rof_char_t mk(input logic [7:0] v, input logic a);
    mk = '0;
    mk.raw = {4'h0, v};
    mk.data = v;
    mk.is_addr = a;
    mk.valid = 1'b1;
  endfunction : mk
  function automatic logic [11:0] exp_map(input rof_pkg::rof_char_t c, input logic [1:0] m);
    if (m == 2'h0)
      return c.raw;
    if (m == 2'h1)
      return {2'h0, c.raw[9:0]};
    if (m == 2'h2)
      return {c.cell_start, c.reserved, c.raw[9:0]};
    return {c.cell_start, c.reserved, 1'b0, ~^{c.data, c.special, c.reserved}, c.data};
  endfunction : exp_map
  task automatic put(input rof_pkg::rof_char_t c);
    @(posedge clk_in);
    char_in <= c;
    @(posedge clk_in);
    char_in <= '0;
    #1;
  endtask : put
  task automatic pkt(input logic [7:0] a, input logic wa, input logic wd);
    put(mk(a, 1'b1));
    cmp({11'h0, buffer_write_out}, {11'h0, wa});
    put(mk(8'h3c, 1'b0));
    cmp({11'h0, buffer_write_out}, {11'h0, wd});
  endtask : pkt
  // register access: select, read enable and receiver reset low together
  task automatic acc(input logic uni, input logic rd, input logic [7:0] v);
    rof_pkg::rof_char_t c;
    c = '0;
    c.special = uni;
    c.reserved = rd;
    @(posedge clk_in);
    char_in <= c;
    bus_in <= {4'h0, v};
    receiver_reset_n_in <= 1'b0;
    go <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    cmp({9'h0, bus_oe_out, read_strobe_out, buf_flags_oe_out}, 12'h007);
    if (rd)
      cmp({4'h0, receive_output_bus_out[7:0]}, {4'h0, v});
    @(posedge clk_in);
    go <= 1'b0;
    receiver_reset_n_in <= 1'b1;
    char_in <= '0;
    repeat (3) @(posedge clk_in);
  endtask : acc
  initial
  begin
    rof_pkg::rof_char_t c;
    logic [31:0] r;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    // random characters across the fixed-layout modes
    repeat (300)
    begin
      r = $random(seed);
      c = mk(r[7:0], 1'b0);
      c.raw = r[19:8];
      {c.special, c.reserved, c.cell_start} = r[22:20];
      @(posedge clk_in);
      codec_bypass_n_in <= r[24];
      width_select_in <= r[23];
      buffer_bypass_n_in <= !r[24];
      buf_flags_in <= r[27:25];
      put(c);
      cmp(receive_output_bus_out, exp_map(c, r[24:23]));
      cmp({8'h0, buf_flags_oe_out, buf_flags_out}, {9'h0, r[27:25]});
    end
    @(posedge clk_in);
    codec_bypass_n_in <= 1'b1;
    width_select_in <= 1'b1;
    buffer_bypass_n_in <= 1'b1;
    acc(1'b1, 1'b0, 8'h05);
    acc(1'b1, 1'b1, 8'h05);
    pkt(8'h05, 1'b1, 1'b1);
    pkt(8'h85, 1'b0, 1'b0);
    @(posedge clk_in);
    discard_policy_in <= 2'h3;
    pkt(8'h05, 1'b0, 1'b1);
    @(posedge clk_in);
    discard_policy_in <= 2'h2;
    acc(1'b0, 1'b0, 8'h12);
    pkt(8'h02, 1'b1, 1'b1);
    acc(1'b1, 1'b1, 8'h05);
    pkt(8'h0c, 1'b0, 1'b0);
    @(posedge clk_in);
    discard_policy_in <= 2'h0;
    pkt(8'h0c, 1'b1, 1'b1);
    @(posedge clk_in);
    discard_policy_in <= 2'h2;
    @(posedge clk_in);
    reset_pair_n_in <= 2'h0;
    @(posedge clk_in);
    reset_pair_n_in <= 2'h3;
    pkt(8'h0c, 1'b1, 1'b1);
    c = mk(8'h00, 1'b0);
    c.cmd_set = 1'b1;
    put(c);
    cmp({10'h0, far_interrupt_out, buffer_write_out}, 12'h002);
    put(mk(8'h5a, 1'b0));
    cmp(receive_output_bus_out, 12'h15a);
    c.cmd_set = 1'b0;
    c.cmd_clr = 1'b1;
    put(c);
    cmp({10'h0, far_interrupt_out, buffer_write_out}, 12'h000);
    finish_test();
  end
endmodule : rof_top_tb
bind rof_top rof_chk #(.BUS_W(BUS_W)) u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .device_select_n_in(device_select_n_in), .read_enable_n_in(read_enable_n_in),
  .codec_bypass_n_in(codec_bypass_n_in), .width_select_in(width_select_in),
  .buffer_bypass_n_in(buffer_bypass_n_in), .receiver_reset_n_in(receiver_reset_n_in),
  .char_in(char_in), .receive_output_bus_out(receive_output_bus_out),
  .bus_oe_out(bus_oe_out), .buf_flags_oe_out(buf_flags_oe_out),
  .far_interrupt_out(far_interrupt_out), .read_strobe_out(read_strobe_out));
